//--- design/ascp_port.sv
/*
  Serial command and register port of a delta-sigma converter with its
  power-up and software reset sequencing.
  Assumes the serial master keeps the link clock still between frames and
  holds each half period of the link clock well above the crossing
  latency of a few system cycles; the read word is prepared in that gap.
  Assumes the system clock runs whenever the link is in use, since every
  register write is applied and every read word is built on that clock.
  Assumes chip select comes from the same master as the link clock, so
  the link flops take it as a synchronous qualifier.
*/
`timescale 1ns/10ps
`default_nettype none

module ascp_port
  import ascp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk_link,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic [23:0] i_conv_result,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [23:0] o_config,
  output logic [23:0] o_offset,
  output logic [23:0] o_gain,
  output logic o_in_reset
);

  // A command is accepted only as a plain register read or write to a
  // defined select; writes to the result register are refused.
  // Conversion and power-save requests are refused as well: this port
  // does not run the converter, so accepting them would leave the host
  // waiting for a data word that never comes.
  function automatic logic cmd_valid(input ascp_cmd_t cmd);
    logic ok;
    ok = cmd.command_flag_bit && !cmd.single_convert_bit && !cmd.continuous_convert_bit
         && !cmd.power_save_bit && (cmd.register_select_field <= SEL_SETUP);
    if (!cmd.read_not_write && (cmd.register_select_field == SEL_RESULT)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : cmd_valid

  // Edge of a synchronised toggle, taken from the second and third stages.
  // The first stage is read by nothing but the second stage.
  function automatic logic toggle_seen(input logic [2:0] sync);
    return sync[2] ^ sync[1];
  endfunction : toggle_seen

  // ---------------- System domain state ----------------
  // The counter is eleven bits wide so the full start-up count fits.
  logic [10:0] rst_cnt_q, rst_cnt_d;
  logic in_reset_q, in_reset_d;
  logic port_rst_q;
  logic reset_valid_q, reset_valid_d;
  logic [23:0] cfg_q, cfg_d;
  logic [23:0] off_q, off_d;
  logic [23:0] gain_q, gain_d;
  logic [RD_HOLD_BITS-1:0] rd_hold_q, rd_hold_d;
  logic [2:0] cmd_sync_q;
  logic [2:0] wr_sync_q;
  logic [1:0] cs_sync_q;
  logic oe_q;

  // ---------------- Link domain state ----------------
  // Everything here runs on the link clock and is cleared by the port reset.
  ascp_mode_t mode_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] word_q;
  logic [23:0] shift_q;
  ascp_cmd_t cmd_q;
  logic cmd_tgl_q;
  ascp_wr_t wr_q;
  logic wr_tgl_q;
  logic sdo_q;

  // ---------------- Link domain decode ----------------
  // The command is decoded from the word that includes the bit arriving at
  // this edge, so the mode changes on the eighth edge itself.
  wire logic [23:0] shift_next = {shift_q[22:0], i_sdi};
  wire ascp_cmd_t cmd_in = shift_next[7:0];
  wire logic cmd_ok = cmd_valid(cmd_in);
  wire logic cmd_done = (mode_q == ST_COMMAND) && (bit_cnt_q == CMD_LAST_BIT);
  wire logic word_done = (mode_q == ST_DATA) && (bit_cnt_q == WORD_LAST_BIT);
  wire logic is_setup = (cmd_q.register_select_field == SEL_SETUP);
  wire logic [1:0] last_word = is_setup ? SETUP_LAST_WORD : SINGLE_LAST_WORD;
  wire logic frame_done = word_done && (word_q == last_word);
  wire logic [2:0] wr_target = is_setup ? {1'b0, word_q} : cmd_q.register_select_field;
  wire logic [6:0] rd_pos = 7'(word_q) * 7'(WORD_BITS) + 7'(bit_cnt_q);
  wire logic [6:0] rd_idx = 7'(RD_HOLD_BITS - 1) - rd_pos;
  wire logic reading = (mode_q == ST_DATA) && cmd_q.read_not_write;

  // Serial receive on the rising link clock edge, command then data mode.
  // The port reset comes from a system flop; the link clock is still at
  // that moment, so its release cannot race a shifting edge.
  always_ff @(posedge i_sclk_link or posedge port_rst_q) begin
    if (port_rst_q) begin
      mode_q <= ST_COMMAND;
      bit_cnt_q <= 5'h00;
      word_q <= 2'h0;
      shift_q <= 24'h000000;
      cmd_q <= '0;
      cmd_tgl_q <= 1'b0;
    end else if (!i_cs_n) begin
      shift_q <= shift_next;
      case (mode_q)
        ST_COMMAND: begin
          bit_cnt_q <= cmd_done ? 5'h00 : bit_cnt_q + 5'h01;
          if (cmd_done && cmd_ok) begin
            mode_q <= ST_DATA;
            cmd_q <= cmd_in;
            cmd_tgl_q <= ~cmd_tgl_q;
            word_q <= 2'h0;
          end
        end
        ST_DATA: begin
          bit_cnt_q <= word_done ? 5'h00 : bit_cnt_q + 5'h01;
          if (frame_done) begin
            mode_q <= ST_COMMAND;
          end else if (word_done) begin
            word_q <= word_q + 2'h1;
          end
        end
        default: begin
          mode_q <= ST_COMMAND;
          bit_cnt_q <= 5'h00;
        end
      endcase
    end
  end

  // Completed write words are held until the next word ends, at least 24
  // link clocks, so the system side reads them long after they settle.
  // A frame left unfinished resumes at the next select; no half word lands.
  always_ff @(posedge i_sclk_link or posedge port_rst_q) begin
    if (port_rst_q) begin
      wr_q <= '0;
      wr_tgl_q <= 1'b0;
    end else if (!i_cs_n && word_done && !cmd_q.read_not_write) begin
      wr_q <= '{target: wr_target, data: shift_next};
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // Serial transmit after the falling edge. The read word is prepared by
  // the system side within a few cycles of the command toggle and then
  // stays fixed for the whole frame, which is what makes this read safe.
  always_ff @(negedge i_sclk_link or posedge port_rst_q) begin
    if (port_rst_q) begin
      sdo_q <= 1'b0;
    end else if (!i_cs_n && reading) begin
      sdo_q <= rd_hold_q[rd_idx];
    end
  end

  // ---------------- System domain ----------------
  // Events from the link are taken only outside a reset cycle, so a toggle
  // undone by the port reset cannot be mistaken for a new command.
  wire logic cmd_evt = toggle_seen(cmd_sync_q);
  wire logic wr_evt = toggle_seen(wr_sync_q) && !in_reset_q;
  wire logic rd_evt = cmd_evt && cmd_q.read_not_write && !in_reset_q;
  wire logic rd_sel_cfg = (cmd_q.register_select_field == SEL_CONFIG);
  wire logic rd_cfg = rd_evt && (rd_sel_cfg || is_setup);
  wire logic wr_cfg = wr_evt && (wr_q.target == SEL_CONFIG);
  wire logic soft_req = wr_cfg && wr_q.data[CFG_RESET_REQ_BIT];
  wire logic req_held = cfg_q[CFG_RESET_REQ_BIT];
  wire logic rst_last = (rst_cnt_q == (req_held ? SOFT_RESET_LAST : STARTUP_LAST));
  // The stored bit under the flag is ignored; reads always show the flag.
  wire logic [23:0] cfg_view = {cfg_q[23:CFG_RESET_VALID_BIT+1], reset_valid_q,
    cfg_q[CFG_RESET_VALID_BIT-1:0]};

  // Reset sequencer: a start-up count after power-up, a short cycle after
  // a software request. Writes are refused while a cycle runs, so a cycle
  // is never restarted. The soft cycle is kept short on purpose: the host
  // cannot reach the port until it ends.
  assign in_reset_d = soft_req ? 1'b1 : (in_reset_q && !rst_last);
  assign rst_cnt_d = (soft_req || !in_reset_q) ? 11'h000 : rst_cnt_q + 11'h001;

  // Reset-valid: set wins over the read clear, and a pending request
  // keeps it set however often the register is read. Only a read taken
  // after the request is written back to zero clears it, so a host that
  // reads first and clears the request afterwards must read once more.
  assign reset_valid_d = in_reset_q || soft_req || req_held
    || (reset_valid_q && !rd_cfg);

  // Register updates; a reset cycle reloads defaults but keeps the request
  // bit so the host still has to write it back to zero.
  always_comb begin
    cfg_d = cfg_q;
    off_d = off_q;
    gain_d = gain_q;
    if (in_reset_q) begin
      cfg_d = CFG_RESET | (24'(req_held) << CFG_RESET_REQ_BIT);
      off_d = OFFSET_RESET;
      gain_d = GAIN_RESET;
    end else if (wr_evt) begin
      case (wr_q.target)
        SEL_OFFSET: off_d = wr_q.data;
        SEL_GAIN: gain_d = wr_q.data;
        SEL_CONFIG: cfg_d = wr_q.data & ~(24'h000001 << CFG_RESET_VALID_BIT);
        default: cfg_d = cfg_q;
      endcase
    end
  end

  // Read word built once per command, set-up group in its fixed order.
  // Single words sit in the top bits so the transmit index is the same
  // for every select; the result is captured when the command lands.
  always_comb begin
    rd_hold_d = rd_hold_q;
    if (rd_evt) begin
      case (cmd_q.register_select_field)
        SEL_OFFSET: rd_hold_d = {off_q, 48'h000000000000};
        SEL_GAIN: rd_hold_d = {gain_q, 48'h000000000000};
        SEL_CONFIG: rd_hold_d = {cfg_view, 48'h000000000000};
        SEL_RESULT: rd_hold_d = {i_conv_result, 48'h000000000000};
        default: rd_hold_d = {off_q, gain_q, cfg_view};
      endcase
    end
  end

  // Sequencer, flags and the port reset.
  // The port reset is a flop of its own so the link flops see a clean
  // edge; it rises and falls together with the reset cycle flag.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_q <= 11'h000;
      in_reset_q <= 1'b1;
      port_rst_q <= 1'b1;
      reset_valid_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      in_reset_q <= in_reset_d;
      port_rst_q <= in_reset_d;
      reset_valid_q <= reset_valid_d;
    end
  end

  // Register file and read hold.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= CFG_RESET;
      off_q <= OFFSET_RESET;
      gain_q <= GAIN_RESET;
      rd_hold_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      off_q <= off_d;
      gain_q <= gain_d;
      rd_hold_q <= rd_hold_d;
    end
  end

  // Crossings into the system clock: toggles for events, two flops for the
  // chip select level that drives the output enable.
  // The enable trails chip select by three cycles, far inside the time the
  // host leaves before the first falling link clock edge.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmd_sync_q <= 3'h0;
      wr_sync_q <= 3'h0;
      cs_sync_q <= 2'h3;
      oe_q <= 1'b0;
    end else begin
      cmd_sync_q <= {cmd_sync_q[1:0], cmd_tgl_q};
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
      cs_sync_q <= {cs_sync_q[0], i_cs_n};
      oe_q <= !cs_sync_q[1];
    end
  end

  // Every output comes straight from a flop.
  assign o_sdo = sdo_q;
  assign o_sdo_oe = oe_q;
  assign o_config = cfg_q;
  assign o_offset = off_q;
  assign o_gain = gain_q;
  assign o_in_reset = in_reset_q;

endmodule : ascp_port

`default_nettype wire

//--- shared/ascp_pkg.sv
/*
  Package for the converter serial command port: register selects, reset
  values, field positions, frame sizes and the carrier structs.
  Assumes a 200 MHz system clock standing in for the converter oscillator.
*/
package ascp_pkg;

  // Frame sizes on the serial link.
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned SETUP_WORDS = 3;
  localparam int unsigned RD_HOLD_BITS = WORD_BITS * SETUP_WORDS;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] WORD_LAST_BIT = 5'h17;
  localparam logic [1:0] SINGLE_LAST_WORD = 2'h0;
  localparam logic [1:0] SETUP_LAST_WORD = 2'h2;

  // Register select codes carried in the command word.
  localparam logic [2:0] SEL_OFFSET = 3'h0;
  localparam logic [2:0] SEL_GAIN = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_RESULT = 3'h3;
  localparam logic [2:0] SEL_SETUP = 3'h4;

  // Reset values of the writable registers.
  localparam logic [23:0] CFG_RESET = 24'h000040;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET = 24'h800000;

  // Configuration bit positions for the reset request and the reset-valid flag.
  localparam int unsigned CFG_RESET_REQ_BIT = 7;
  localparam int unsigned CFG_RESET_VALID_BIT = 6;

  // Reset sequencing in oscillator cycles.
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam int unsigned SOFT_RESET_CYCLES = 16;
  localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);
  localparam logic [10:0] SOFT_RESET_LAST = 11'(SOFT_RESET_CYCLES - 1);

  // Command word layout, bit 7 down to bit 0.
  typedef struct packed {
    logic command_flag_bit;
    logic single_convert_bit;
    logic continuous_convert_bit;
    logic read_not_write;
    logic [2:0] register_select_field;
    logic power_save_bit;
  } ascp_cmd_t;

  // One completed write word with the register it goes to.
  typedef struct packed {
    logic [2:0] target;
    logic [23:0] data;
  } ascp_wr_t;

  // Serial port modes, one-hot.
  typedef enum logic [1:0] {
    ST_COMMAND = 2'b01,
    ST_DATA = 2'b10
  } ascp_mode_t;

endpackage : ascp_pkg

//--- tb/ascp_port_assertions.sv
/*
  Checker for the converter serial command port, bound to its top module.
  Assumes the link clock idles low between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module ascp_port_checker
  import ascp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk_link,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic [23:0] i_conv_result,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic [23:0] o_config,
  input wire logic [23:0] o_offset,
  input wire logic [23:0] o_gain,
  input wire logic o_in_reset
);
  logic [10:0] cnt_q;
  logic first_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Length of the running reset window; the first window is the start-up one.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 11'h000;
      first_q <= 1'b1;
    end else begin
      cnt_q <= o_in_reset ? cnt_q + 11'h001 : 11'h000;
      first_q <= first_q & o_in_reset;
    end
  end
  a_startup_len: assert property (first_q && $fell(o_in_reset) |->
    cnt_q inside {[11'h3FC:11'h406]}) else $error("start-up window length wrong");
  a_startup_bound: assert property (first_q |-> cnt_q <= 11'h406)
    else $error("start-up window runs too long");
  a_reset_values: assert property ($fell(o_in_reset) |-> o_offset == OFFSET_RESET &&
    o_gain == GAIN_RESET && o_config[23:8] == 16'h0000) else $error("reset values wrong");
  a_soft_len: assert property (!first_q && $fell(o_in_reset) |->
    cnt_q inside {[11'h00C:11'h014]}) else $error("soft reset length wrong");
  a_rs_kept: assert property ($rose(o_in_reset) ##1 o_in_reset |-> o_config[7])
    else $error("reset request lost during reset");
  a_oe_off: assert property (i_cs_n [*4] |-> !o_sdo_oe)
    else $error("output driven while deselected");
  a_oe_on: assert property ((!i_cs_n && !o_in_reset) [*6] |-> o_sdo_oe)
    else $error("output not driven while selected");
  a_sdo_edge: assert property ($changed(o_sdo) |-> !i_sclk_link || o_in_reset)
    else $error("output bit changed while link clock high");
  a_regs_quiet: assert property ($changed(o_gain) || $changed(o_offset) |->
    !i_cs_n || o_in_reset || $past(o_in_reset)) else $error("register changed outside frame");
  c_soft: cover property (!first_q && $fell(o_in_reset));
  c_gain: cover property ($changed(o_gain));
  c_oe: cover property ($rose(o_sdo_oe));
endmodule : ascp_port_checker

bind ascp_port ascp_port_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_sclk_link(i_sclk_link), .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_conv_result(i_conv_result),
  .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_config(o_config), .o_offset(o_offset),
  .o_gain(o_gain), .o_in_reset(o_in_reset));
`default_nettype wire

//--- tb/ascp_host.sv
/*
  Host model: a serial master that frames command and data words.
  Assumes nothing of the system clock; its own link clock idles low.
*/
`timescale 1ns/10ps
`default_nettype none
module ascp_host (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  logic [95:0] rx;
  event done;
  // Idle levels; the data line never keeps a stale value between frames.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // Sends n bits of tx; slow stretches each low phase to mimic a lazy master.
  task automatic frame(input logic [95:0] tx, input int n, input int slow);
    rx = '0;
    #1.7 o_cs_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      #20 o_sdi = tx[i];
      #(60 + slow) o_sclk = 1'b1;
      rx = {rx[94:0], i_sdo_oe ? i_sdo : 1'bx};
      #80 o_sclk = 1'b0;
    end
    #100 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    -> done;
  endtask : frame
endmodule : ascp_host
`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench for the converter serial command port.
  Assumes the checker binds itself and the host model drives the link.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import ascp_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [23:0] conv = 24'h000000;
  wire cs_n, sclk, serial_data_in, serial_data_out, sdo_oe, in_reset;
  wire [23:0] cfg, offs, gain;
  logic [71:0] expq[$];
  int wq[$];
  int errors = 0;
  int compares = 0;
  int w;
  logic [23:0] v0, v1, v2;

  always #2.5 i_clk_sys = ~i_clk_sys;

  ascp_port dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk_link(sclk), .i_cs_n(cs_n),
    .i_sdi(serial_data_in), .i_conv_result(conv), .o_sdo(serial_data_out), .o_sdo_oe(sdo_oe), .o_config(cfg),
    .o_offset(offs), .o_gain(gain), .o_in_reset(in_reset));
  ascp_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(serial_data_in), .i_sdo(serial_data_out), .i_sdo_oe(sdo_oe));

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Read frames note their expected word first; setup reads carry three words.
  task automatic rd(input logic [2:0] sel, input logic [71:0] exp);
    int n = (sel == SEL_SETUP) ? 80 : 32;
    expq.push_back(exp);
    wq.push_back(n / 24);
    host.frame(96'({4'h9, sel, 1'b0}) << (n - 8), n, $urandom_range(0, 40));
    @(negedge i_clk_sys);
  endtask : rd

  task automatic wr(input logic [2:0] sel, input logic [71:0] data);
    int n = (sel == SEL_SETUP) ? 80 : 32;
    host.frame((96'({4'h8, sel, 1'b0}) << (n - 8)) | 96'(data), n, 0);
    @(negedge i_clk_sys);
  endtask : wr

  // Each finished frame with a pending note is compared against the oldest note.
  always @(host.done) begin
    if (expq.size() > 0) begin
      w = wq.pop_front();
      check("read word", (w == 3) ? host.rx[71:0] : 72'(host.rx[23:0]), expq.pop_front());
    end
  end

  // Start-up waits are bounded so a stuck reset ends the run.
  task automatic wait_ready;
    int k = 0;
    while (in_reset !== 1'b0 && k < 3000) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (in_reset !== 1'b0) begin
      errors++;
      complete_run();
    end
    @(negedge i_clk_sys);
  endtask : wait_ready

  // Main sequence: power-up, register traffic, refused commands, soft reset.
  initial begin
    void'($urandom(89082));
    repeat (10) @(negedge i_clk_sys);
    i_rst = 1'b0;
    wait_ready();
    rd(SEL_SETUP, {OFFSET_RESET, GAIN_RESET, CFG_RESET});
    rd(SEL_CONFIG, 72'h0);
    v0 = 24'($urandom);
    v1 = 24'($urandom);
    v2 = 24'($urandom) & 24'hFFFF3F;
    wr(SEL_OFFSET, 72'(v0));
    wr(SEL_GAIN, 72'(v1));
    wr(SEL_CONFIG, 72'(v2));
    check("gain pin", 72'(gain), 72'(v1));
    check("config pin", 72'(cfg), 72'(v2));
    rd(SEL_SETUP, {v0, v1, v2});
    expq.push_back(72'(v1));
    wq.push_back(1);
    host.frame(96'({56'h00D2B2939A8692, 24'h000000}), 80, 0);
    @(negedge i_clk_sys);
    conv = 24'($urandom);
    rd(SEL_RESULT, 72'(conv));
    wr(SEL_SETUP, {v1, v0, 24'h000000});
    // The enable trails chip select through its synchroniser.
    repeat (4) @(negedge i_clk_sys);
    check("offset pin", 72'(offs), 72'(v1));
    check("setup gain pin", 72'(gain), 72'(v0));
    check("setup config pin", 72'(cfg), 72'h0);
    check("idle enable", 72'(sdo_oe), 72'h0);
    rd(SEL_OFFSET, 72'(v1));
    wr(SEL_CONFIG, 72'h000080);
    wait_ready();
    rd(SEL_SETUP, {OFFSET_RESET, GAIN_RESET, 24'h0000C0});
    rd(SEL_CONFIG, 72'h0000C0);
    wr(SEL_CONFIG, 72'h000000);
    rd(SEL_CONFIG, 72'(CFG_RESET));
    rd(SEL_CONFIG, 72'h0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
